// File: verilog/osc_pkg.sv
// Package for the output stream control and readback block
package osc_pkg;

    // ------------------------------------------------------------
    // Register map (word byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OSC_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] OSC_ADDR_IQ0    = 8'h10;   // I/Q pairs: +8*loop, I then Q
    localparam logic [7:0] OSC_ADDR_SS0    = 8'h80;   // Strength words: +4*loop
    localparam int         OSC_LOOPS       = 6;

    // ------------------------------------------------------------
    // Control field layout and reset
    // ------------------------------------------------------------
    localparam int         OSC_DIV_LSB     = 8;
    localparam int         OSC_MASTER_BIT  = 7;
    localparam int         OSC_PAIR_LSB    = 4;
    localparam int         OSC_STREAM_LSB  = 0;
    localparam logic [9:0] OSC_CTRL_RESET  = 10'h000;

    // ------------------------------------------------------------
    // Stream grouping: each channel carries the index of its stream
    // ------------------------------------------------------------
    typedef logic [2:0] osc_grp_t [6];

    typedef struct packed {
        logic [15:0] iSample;
        logic [15:0] qSample;
        logic [11:0] strength;
    } osc_loop_t;

endpackage

// File: verilog/osc_output_control.sv
// Output port control register, clock divider and loop readback
//
// Functional notes
// RULE1: Master mode divides core clock by 1,2,4,8 for divisor codes 0..3.
// RULE2: Divisor field is ignored while the port clock comes from outside.
// RULE3: Master bit set: drive port clock pin, launch data on it.
// RULE4: Master bit clear: port clock pin is input, data follows external clock.
// RULE5: Reset clears master bit so the clock pin starts as an input.
// RULE6: Pairing code 000 forms no complex pairs; stream code alone decides.
// RULE7: Pairing 001/010/011 pair 0-1, then 2-3, then 4-5 as complex.
// RULE8: Pairing 101/110/111 pair 0-1, then 2-3, then 4-5 as biphase.
// RULE9: Pairing 100 is reserved and behaves as no pairing.
// RULE10: Stream codes 0..3 merge channels 0..1/2/3/4, giving 5/4/3/2 streams.
// RULE11: Code 4 merges all six; code 5 forms 0-2 and 3-5.
// RULE12: Code 6 pairs 0-1,2-3,4-5; code 7 pairs 0-1,2-3, rest independent.
// RULE13: Code 8 forms 0-2, 3-4, 5; code 9 forms 0-3 and 4-5.
// RULE14: Any other stream code keeps all six channels independent.
// RULE15: Per loop a read-only 16-bit latest in-phase sample, even if bypassed.
// RULE16: Per loop a read-only 16-bit latest quadrature sample, even if bypassed.
// RULE17: Strength word updates only while its loop is enabled and operating.
`timescale 1ns/1ps
`default_nettype none
module osc_output_control
    import osc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Wishbone classic slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatI,
    output logic      [31:0] wbDatO,
    output logic             wbAck,
    // Datapath samples from the six gain loops
    input  wire logic [5:0]  sampleValid,
    input  wire osc_loop_t [5:0] loopData,
    input  wire logic [5:0]  loopActive,
    // Port clock pin, as three signals
    input  wire logic        portClkIn,
    output logic             portClkOut,
    output logic             portClkOe,
    // Data launch strobe and configuration to the datapath
    output logic             launchStrobe,
    output logic [5:0]       complexPair,
    output logic [5:0]       biphasePair,
    output osc_grp_t         streamOf,
    output logic [2:0]       streamCount
);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [9:0]  ctrlReg;
    logic [15:0] iReg [6];
    logic [15:0] qReg [6];
    logic [11:0] ssReg [6];
    logic        busReq;
    logic        wrCtrl;

    assign busReq = wbCyc && wbStb && !wbAck;
    assign wrCtrl = busReq && wbWe && (wbAdr == OSC_ADDR_CTRL);

    // Byte lanes 0 and 1 hold the ten control bits
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrlReg <= OSC_CTRL_RESET;                          // [RULE5]
        end else if (wrCtrl) begin
            if (wbSel[0]) ctrlReg[7:0] <= wbDatI[7:0];
            if (wbSel[1]) ctrlReg[9:8] <= wbDatI[9:8];
        end
    end

    // ------------------------------------------------------------
    // Port clock generation
    // ------------------------------------------------------------
    logic       master;
    logic [1:0] divSel;
    logic [2:0] divCnt_reg;
    logic       pinClk_reg;
    logic       extClk_s1_reg;
    logic       extClk_s2_reg;
    logic       extClk_d_reg;

    assign master = ctrlReg[OSC_MASTER_BIT];
    assign divSel = ctrlReg[OSC_DIV_LSB +: 2];

    // Free-running counter; bit k toggles at core/2^(k+1)
    always_ff @(posedge clk) begin
        if (!rstn) divCnt_reg <= 3'h0;
        else       divCnt_reg <= divCnt_reg + 3'h1;
    end

    // Divide by 1 passes the core clock level; registered versions otherwise
    always_ff @(posedge clk) begin
        if (!rstn) pinClk_reg <= 1'b0;
        else       pinClk_reg <= (divSel == 2'h1) ? ~divCnt_reg[0] :
                                 (divSel == 2'h2) ? ~divCnt_reg[1] :
                                 ~divCnt_reg[2];                // [RULE1]
    end

    // Divide by 1 is the core clock itself, gated by master only
    assign portClkOut = master && ((divSel == 2'h0) ? clk : pinClk_reg); // [RULE1] [RULE3]
    assign portClkOe  = master;                                 // [RULE3] [RULE4]

    // External clock sampled through two stages; only the second is edge-checked
    always_ff @(posedge clk) begin
        if (!rstn) begin
            extClk_s1_reg <= 1'b0;
            extClk_s2_reg <= 1'b0;
            extClk_d_reg  <= 1'b0;
        end else begin
            extClk_s1_reg <= portClkIn;
            extClk_s2_reg <= extClk_s1_reg;
            extClk_d_reg  <= extClk_s2_reg;
        end
    end

    // Launch once per divided period when the counter's low divisor bits are all ones, or on the external rising edge; divisor unused in slave
    logic launchNext;
    always_comb begin
        if (master) begin
            unique case (divSel)
                2'h0: launchNext = 1'b1;
                2'h1: launchNext = (divCnt_reg[0] == 1'b1);
                2'h2: launchNext = (divCnt_reg[1:0] == 2'h3);
                2'h3: launchNext = (divCnt_reg == 3'h7);
            endcase                                             // [RULE3]
        end else begin
            launchNext = extClk_s2_reg && !extClk_d_reg;        // [RULE2] [RULE4]
        end
    end
    assign launchStrobe = launchNext;

    // ------------------------------------------------------------
    // Channel pairing decode
    // ------------------------------------------------------------
    logic [2:0] pairCode;
    assign pairCode = ctrlReg[OSC_PAIR_LSB +: 3];

    always_comb begin
        complexPair = 6'h00;
        biphasePair = 6'h00;
        unique case (pairCode)
            3'h0, 3'h4: complexPair = 6'h00;                    // [RULE6] [RULE9]
            3'h1: complexPair = 6'h03;                          // [RULE7]
            3'h2: complexPair = 6'h0F;                          // [RULE7]
            3'h3: complexPair = 6'h3F;                          // [RULE7]
            3'h5: biphasePair = 6'h03;                          // [RULE8]
            3'h6: biphasePair = 6'h0F;                          // [RULE8]
            3'h7: biphasePair = 6'h3F;                          // [RULE8]
        endcase
    end

    // ------------------------------------------------------------
    // Stream combining decode
    // ------------------------------------------------------------
    logic [3:0] strCode;
    assign strCode = ctrlReg[OSC_STREAM_LSB +: 4];

    // Group index per channel, channel 0 first
    always_comb begin
        streamOf = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};      // [RULE14]
        streamCount = 3'h6;                                     // [RULE14]
        case (strCode)
            4'h0: begin streamOf = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4}; streamCount = 3'h5; end // [RULE10]
            4'h1: begin streamOf = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3}; streamCount = 3'h4; end // [RULE10]
            4'h2: begin streamOf = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2}; streamCount = 3'h3; end // [RULE10]
            4'h3: begin streamOf = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1}; streamCount = 3'h2; end // [RULE10]
            4'h4: begin streamOf = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0}; streamCount = 3'h1; end // [RULE11]
            4'h5: begin streamOf = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1}; streamCount = 3'h2; end // [RULE11]
            4'h6: begin streamOf = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2}; streamCount = 3'h3; end // [RULE12]
            4'h7: begin streamOf = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3}; streamCount = 3'h4; end // [RULE12]
            4'h8: begin streamOf = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2}; streamCount = 3'h3; end // [RULE13]
            4'h9: begin streamOf = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1}; streamCount = 3'h2; end // [RULE13]
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // Readback capture
    // ------------------------------------------------------------
    // Samples follow the datapath even with the loop bypassed
    always_ff @(posedge clk) begin
        for (int k = 0; k < OSC_LOOPS; k++) begin
            if (!rstn) begin
                iReg[k] <= 16'h0000;
                qReg[k] <= 16'h0000;
            end else if (sampleValid[k]) begin
                iReg[k] <= loopData[k].iSample;                 // [RULE15]
                qReg[k] <= loopData[k].qSample;                 // [RULE16]
            end
        end
    end

    // Strength words hold while the loop is idle
    always_ff @(posedge clk) begin
        for (int k = 0; k < OSC_LOOPS; k++) begin
            if (!rstn)                                   ssReg[k] <= 12'h000;
            else if (sampleValid[k] && loopActive[k])    ssReg[k] <= loopData[k].strength; // [RULE17]
        end
    end

    // ------------------------------------------------------------
    // Bus read mux and acknowledge
    // ------------------------------------------------------------
    logic [31:0] rdNext;
    always_comb begin
        rdNext = 32'h0000_0000;
        if (wbAdr == OSC_ADDR_CTRL) rdNext = {22'h000000, ctrlReg};
        for (int k = 0; k < OSC_LOOPS; k++) begin
            if (wbAdr == OSC_ADDR_IQ0 + 8'(8 * k))     rdNext = {16'h0000, iReg[k]};
            if (wbAdr == OSC_ADDR_IQ0 + 8'(8 * k + 4)) rdNext = {16'h0000, qReg[k]};
            if (wbAdr == OSC_ADDR_SS0 + 8'(4 * k))     rdNext = {20'h00000, ssReg[k]};
        end
    end

    // One wait state; unmapped reads return zero, writes to them are dropped
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wbAck  <= 1'b0;
            wbDatO <= 32'h0000_0000;
        end else begin
            wbAck  <= busReq;
            wbDatO <= (busReq && !wbWe) ? rdNext : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    reset_master_a: assert property (@(posedge clk) !rstn |=> !portClkOe) // [RULE5]
        else $error("clock pin driven after reset");
    slave_no_drive_a: assert property (@(posedge clk) disable iff (!rstn) !master |-> !portClkOe) // [RULE4]
        else $error("clock pin driven in slave mode");
    div8_period_a: assert property (@(posedge clk) disable iff (!rstn)
        (master && divSel == 2'h3 && launchStrobe) ##1 (master && divSel == 2'h3)[*7] |=> launchStrobe)
        else $error("divide by eight launch spacing wrong"); // [RULE1]
    div2_gap_a: assert property (@(posedge clk) disable iff (!rstn)
        (master && divSel == 2'h1 && launchStrobe) ##1 (master && divSel == 2'h1) |-> !launchStrobe)
        else $error("divide by two launched twice running"); // [RULE1]
    slave_edge_a: assert property (@(posedge clk) disable iff (!rstn)
        !master |-> (launchStrobe == (extClk_s2_reg && !extClk_d_reg)))
        else $error("slave launch not tied to external edge"); // [RULE2]
    pair_excl_a: assert property (@(posedge clk) disable iff (!rstn)
        (complexPair & biphasePair) == 6'h00 && (pairCode != 3'h4 || (complexPair == 6'h00 && biphasePair == 6'h00)))
        else $error("pairing decode conflict"); // [RULE9]
    stream_all_a: assert property (@(posedge clk) disable iff (!rstn)
        strCode == 4'h4 |-> streamCount == 3'h1 && streamOf[5] == 3'h0)
        else $error("code four not single stream"); // [RULE11]
    stream_dflt_a: assert property (@(posedge clk) disable iff (!rstn)
        strCode > 4'h9 |-> streamCount == 3'h6 && streamOf[5] == 3'h5)
        else $error("unlisted code not independent"); // [RULE14]
    iq_capture_a: assert property (@(posedge clk) disable iff (!rstn)
        sampleValid[0] |=> iReg[0] == $past(loopData[0].iSample) && qReg[0] == $past(loopData[0].qSample))
        else $error("sample not captured"); // [RULE15] [RULE16]
    ss_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        !loopActive[1] |=> $stable(ssReg[1]))
        else $error("strength changed while loop idle"); // [RULE17]
    ack_once_a: assert property (@(posedge clk) disable iff (!rstn)
        wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
        else $error("bus ack timing wrong");

endmodule
`default_nettype wire

// File: tb/osc_sink_model.sv
// Downstream sink model that supplies the port clock in slave mode
`timescale 1ns/1ps
`default_nettype none
module osc_sink_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Bench control
    input  wire logic       run,
    // Supplied port clock and its rising-edge count
    output logic            portClk,
    output logic [7:0]      edgeCount
);
    logic [1:0] phase;

    // Toggle every 4 cycles; finish a high phase so the clock parks low between bursts
    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase     <= 2'h0;
            portClk   <= 1'b0;
            edgeCount <= 8'h00;
        end else if (run || portClk) begin
            phase <= phase + 2'h1;
            if (phase == 2'h3) begin
                portClk <= ~portClk;
                if (!portClk) begin
                    edgeCount <= edgeCount + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/output_stream_control_readback_tb_top.sv
// Self-checking bench for the output control register block
`timescale 1ns/1ps
`default_nettype none
module output_stream_control_readback_tb_top
    import osc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and expectation tables
    // ------------------------------------------------------------
    logic clk = 1'b0, rstn = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, portClkOut, portClkOe;
    logic [7:0] wbAdr = 8'h00, edgeCount;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatI = 32'h0, wbDatO, rd;
    logic [5:0] sampleValid = 6'h00, loopActive = 6'h15, complexPair, biphasePair;
    osc_loop_t [5:0] loopData = '0;
    logic launchStrobe, sinkClk, sinkRun = 1'b0, portPin;
    osc_grp_t streamOf;
    logic [2:0] streamCount;
    logic [4:0] adj;
    int failures = 0, checked = 0, strobes;
    localparam logic [2:0] STREAMS [16] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h2, 3'h3, 3'h4,
                                            3'h3, 3'h2, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6};
    // Bit i-1 set when channel i shares a stream with channel i-1
    localparam logic [4:0] ADJ [16] = '{5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F, 5'h1B, 5'h15, 5'h05,
                                        5'h0B, 5'h17, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
    localparam logic [5:0] PM [8] = '{6'h00, 6'h03, 6'h0F, 6'h3F, 6'h00, 6'h03, 6'h0F, 6'h3F};

    always #5 clk = ~clk;
    // Pin level: the design drives only while its enable is high
    assign portPin = portClkOe ? portClkOut : sinkClk;

    osc_output_control osc_output_control_inst (.clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
        .sampleValid(sampleValid), .loopData(loopData), .loopActive(loopActive), .portClkIn(portPin),
        .portClkOut(portClkOut), .portClkOe(portClkOe), .launchStrobe(launchStrobe),
        .complexPair(complexPair), .biphasePair(biphasePair), .streamOf(streamOf), .streamCount(streamCount));
    osc_sink_model osc_sink_model_inst (.clk(clk), .rstn(rstn), .run(sinkRun), .portClk(sinkClk),
        .edgeCount(edgeCount));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    // One classic cycle; held until ack is sampled high, then released for a cycle
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDatI <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        rd = wbDatO;
        if (n >= 50) failures++;
        wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
        @(posedge clk);
    endtask

    // Count launch strobes over a number of cycles
    task automatic countStrobes(input int cycles);
        strobes = 0;
        repeat (cycles) begin
            @(posedge clk);
            if (launchStrobe === 1'b1) strobes++;
        end
    endtask

    task automatic results;
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        xfer(1'b0, OSC_ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        chk("oe reset", 32'h0, {31'h0, portClkOe});
        // Master mode at each divisor: 32 cycles hold exactly 32/2^d strobes
        for (int d = 0; d < 4; d++) begin
            xfer(1'b1, OSC_ADDR_CTRL, (d << 8) | 32'h80);
            countStrobes(32);
            chk("master strobes", 32 >> d, strobes);
            chk("oe master", 32'h1, {31'h0, portClkOe});
        end
        // Slave mode with divisor 8 set: one strobe per supplied edge
        xfer(1'b1, OSC_ADDR_CTRL, 32'h300);
        chk("oe slave", 32'h0, {31'h0, portClkOe});
        chk("pin drive slave", 32'h0, {31'h0, portClkOut});
        sinkRun <= 1'b1;
        countStrobes(64);
        sinkRun <= 1'b0;
        begin
            int held;
            held = strobes;
            countStrobes(12);
            chk("slave strobes", edgeCount, held + strobes);
        end
        chk("slave edges", 32'h8, edgeCount);
        // Every pairing code, stream code zero
        for (int p = 0; p < 8; p++) begin
            xfer(1'b1, OSC_ADDR_CTRL, p << 4);
            chk("complex", (p < 4) ? PM[p] : 6'h00, complexPair);
            chk("biphase", (p > 4) ? PM[p] : 6'h00, biphasePair);
        end
        // Every stream code, no pairing
        for (int s = 0; s < 16; s++) begin
            xfer(1'b1, OSC_ADDR_CTRL, s);
            for (int i = 1; i < 6; i++) adj[i-1] = (streamOf[i] === streamOf[i-1]);
            chk("stream count", STREAMS[s], streamCount);
            chk("stream groups", ADJ[s], adj);
        end
        // One sample per loop; odd loops are inactive so their strength stays clear
        for (int k = 0; k < 6; k++) begin
            loopData[k] <= {16'hA000 + 16'(k), 16'h5000 + 16'(k), 12'h7C0 + 12'(k)};
            sampleValid <= 6'h01 << k;
            @(posedge clk);
            sampleValid <= 6'h00;
            @(posedge clk);
        end
        xfer(1'b1, OSC_ADDR_IQ0, 32'h1234);
        for (int k = 0; k < 6; k++) begin
            xfer(1'b0, OSC_ADDR_IQ0 + 8'(8 * k), 32'h0);
            chk("in-phase", 32'hA000 + k, rd);
            xfer(1'b0, OSC_ADDR_IQ0 + 8'(8 * k + 4), 32'h0);
            chk("quadrature", 32'h5000 + k, rd);
            xfer(1'b0, OSC_ADDR_SS0 + 8'(4 * k), 32'h0);
            chk("strength", k[0] ? 32'h0 : 32'h7C0 + k, rd);
        end
        xfer(1'b0, 8'hF0, 32'h0);
        chk("unmapped", 32'h0, rd);
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        results();
    end
endmodule
`default_nettype wire
